// ===== frt_pkg.sv
// Constants shared by the free-running timer, compare and capture logic.
// Assumes one 200 MHz clock and a synchronous active-high reset.
// Overview of operation
// - Counter starts at zero after reset
// - Counter is reference for compare and capture
// - Increment once per count clock tick
// - Overflow wraps counter to zero
// - Compare-clear mode clears on compare zero match
// - Writing clear bit clears counter
// - Writing zero while stopped clears counter
// - Overflow and compare match raise interrupts
// - Software clear immediate, match clear on tick
// - Compare equality sets compare flag
// - Valid edge latches counter and flags
// - Edge select 00 disables, else rise/fall/both
// - Flags clear on zero write, enables gate
// - Compare halts while timer stopped
package frt_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ===== frt_tick_div.sv
// Count clock divider: one-cycle tick every 2**(sel+1) sys_clk cycles.
// Assumes sys_clk and synchronous reset; halted while stop is high.
`timescale 1ns/10ps
`default_nettype none
module frt_tick_div
  import frt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stop,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic [7:0] mask;

  always_comb begin
    mask = 8'hFF >> (3'h7 - sel);
    nxt_div = stop ? div_ff : div_ff + 8'h01;
    tick = !stop && ((div_ff & mask) == mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end
endmodule
`default_nettype wire

// ===== frt_capture_ch.sv
// One input capture channel: synchroniser, edge detector, data latch.
// Assumes the pin is asynchronous to sys_clk; flag clear is a pulse.
`timescale 1ns/10ps
`default_nettype none
module frt_capture_ch
  import frt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  input wire logic [15:0] count,
  input wire logic flag_clear,
  output logic [15:0] value,
  output logic flag
);
  logic sync1_ff, sync2_ff, last_ff, flag_ff;
  logic nxt_last, nxt_flag, hit;
  logic [15:0] value_ff, nxt_value;

  always_comb begin
    nxt_last = sync2_ff;
    case (edge_sel)
      EDGE_RISE: hit = sync2_ff && !last_ff;
      EDGE_FALL: hit = !sync2_ff && last_ff;
      EDGE_BOTH: hit = sync2_ff != last_ff;
      default: hit = 1'b0;
    endcase
    nxt_value = hit ? count : value_ff;
    nxt_flag = hit || (flag_ff && !flag_clear);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
      flag_ff <= 1'b0;
      value_ff <= CNT_RESET;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      last_ff <= nxt_last;
      flag_ff <= nxt_flag;
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;
  assign flag = flag_ff;

  a_capture_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (edge_sel == EDGE_RISE && sync2_ff && !last_ff) |=>
    (flag_ff && value_ff == $past(count)))
    else $error("capture missed rising edge");
  a_capture_off: assert property (@(posedge sys_clk) disable iff (rst)
    (edge_sel == EDGE_OFF && !flag_ff) |=> !flag_ff)
    else $error("capture fired while disabled");
endmodule
`default_nettype wire

// ===== free_running_timer_capture_compare.sv
// Top: 16-bit free-running counter with one compare and capture channels.
// Assumes control ports are synchronous; write strobes are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module free_running_timer_capture_compare
  import frt_pkg::*;
#(
  parameter int N_CAP = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic timer_stop,
  input wire logic [2:0] count_clock_sel,
  input wire logic compare_clear_mode,
  input wire logic overflow_irq_enable,
  input wire logic counter_clear_bit,
  input wire logic counter_write,
  input wire logic [15:0] counter_write_data,
  input wire logic overflow_flag_clear,
  input wire logic [15:0] compare_value_zero,
  input wire logic compare_enable,
  input wire logic compare_irq_enable_zero,
  input wire logic compare_flag_clear,
  input wire logic [N_CAP-1:0] capture_pin,
  input wire logic [2*N_CAP-1:0] capture_edge_select,
  input wire logic [N_CAP-1:0] capture_irq_enable,
  input wire logic [N_CAP-1:0] capture_flag_clear,
  output logic [15:0] timer_counter_data,
  output logic overflow_flag,
  output logic compare_match,
  output logic compare_flag_zero,
  output logic [16*N_CAP-1:0] capture_values,
  output logic [N_CAP-1:0] capture_flags,
  output logic timer_irq,
  output logic compare_irq,
  output logic [N_CAP-1:0] capture_irq
);
  import frt_pkg::*;

  logic tick;
  logic [15:0] cnt_ff, nxt_cnt;
  logic ovf_ff, nxt_ovf, match_ff, nxt_match, cflag_ff, nxt_cflag;
  logic tirq_ff, nxt_tirq, cirq_ff, nxt_cirq;
  logic [N_CAP-1:0] capirq_ff, nxt_capirq;
  logic [16*N_CAP-1:0] cap_val;
  logic [N_CAP-1:0] cap_flag;
  logic sw_clear, wrap, cmp_clear, eq;

  frt_tick_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .stop(timer_stop),
    .sel(count_clock_sel),
    .tick(tick)
  );

  genvar g;
  generate
    for (g = 0; g < N_CAP; g++) begin : g_cap
      frt_capture_ch u_cap (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(capture_pin[g]),
        .edge_sel(capture_edge_select[2*g +: 2]),
        .count(cnt_ff),
        .flag_clear(capture_flag_clear[g]),
        .value(cap_val[16*g +: 16]),
        .flag(cap_flag[g])
      );
    end
  endgenerate

  // Clear and load decode, shared by the counter and the flags
  always_comb begin
    eq = cnt_ff == compare_value_zero;
    // Software clear and stopped zero-write act at once
    sw_clear = counter_clear_bit;
    if (counter_write && timer_stop && counter_write_data == CNT_RESET) begin
      sw_clear = 1'b1;
    end
    // A match clear waits for the next count tick
    wrap = tick && cnt_ff == CNT_MAX;
    cmp_clear = tick && compare_clear_mode && eq;
  end

  // Counter: any clear wins over a load or a step
  always_comb begin
    if (sw_clear || cmp_clear || wrap) begin
      nxt_cnt = CNT_RESET;
    end else if (counter_write && timer_stop) begin
      nxt_cnt = counter_write_data;
    end else if (tick) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Compare: one-cycle match pulse and a sticky flag
  always_comb begin
    // Compare only acts on count ticks, so it halts while stopped
    nxt_match = compare_enable && tick && eq;
    // A new match wins over a clear pulse in the same cycle
    nxt_cflag = nxt_match || (cflag_ff && !compare_flag_clear);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      match_ff <= 1'b0;
      cflag_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
      cflag_ff <= nxt_cflag;
    end
  end

  // Overflow flag, set even when another clear coincides with the wrap
  always_comb begin
    nxt_ovf = wrap || (ovf_ff && !overflow_flag_clear);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= nxt_ovf;
    end
  end

  // Interrupt requests: each flag gated by its enable
  always_comb begin
    nxt_tirq = nxt_ovf && overflow_irq_enable;
    nxt_cirq = nxt_cflag && compare_irq_enable_zero;
    nxt_capirq = cap_flag & capture_irq_enable;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tirq_ff <= 1'b0;
      cirq_ff <= 1'b0;
      capirq_ff <= '0;
    end else begin
      tirq_ff <= nxt_tirq;
      cirq_ff <= nxt_cirq;
      capirq_ff <= nxt_capirq;
    end
  end

  assign timer_counter_data = cnt_ff;
  assign overflow_flag = ovf_ff;
  assign compare_match = match_ff;
  assign compare_flag_zero = cflag_ff;
  assign capture_values = cap_val;
  assign capture_flags = cap_flag;
  assign timer_irq = tirq_ff;
  assign compare_irq = cirq_ff;
  assign capture_irq = capirq_ff;

  a_reset_zero: assert property (@(posedge sys_clk)
    $past(rst) |-> cnt_ff == CNT_RESET)
    else $error("counter not zero after reset");
  a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
    (tick && !counter_clear_bit && !counter_write && cnt_ff != CNT_MAX
     && !(compare_clear_mode && eq)) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not step on tick");
  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (tick && cnt_ff == CNT_MAX) |=> (cnt_ff == CNT_RESET && ovf_ff))
    else $error("overflow did not wrap and flag");
  a_cmp_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (tick && compare_clear_mode && eq) |=> cnt_ff == CNT_RESET)
    else $error("compare clear missed");
  a_sw_clear: assert property (@(posedge sys_clk) disable iff (rst)
    counter_clear_bit |=> cnt_ff == CNT_RESET)
    else $error("software clear missed");
  a_stop_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_stop && counter_write && counter_write_data == CNT_RESET)
    |=> cnt_ff == CNT_RESET)
    else $error("stopped zero write missed");
  a_ovf_irq: assert property (@(posedge sys_clk) disable iff (rst)
    (ovf_ff && overflow_irq_enable) |=> ##0 (tirq_ff || !overflow_irq_enable
     || !ovf_ff))
    else $error("overflow interrupt missing");
  a_cmp_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (compare_enable && tick && eq) |=> (match_ff && cflag_ff))
    else $error("compare match not flagged");
  a_stop_hold: assert property (@(posedge sys_clk) disable iff (rst)
    timer_stop [*2] |-> !match_ff)
    else $error("compare active while stopped");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (cflag_ff && !compare_flag_clear) |=> cflag_ff)
    else $error("compare flag lost without clear");

  // Without a tick or a request the counter holds
  a_cnt_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!tick && !counter_clear_bit && !counter_write)
    |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved without tick");

  // Equality alone does not clear; the tick does
  a_match_tick: assert property (@(posedge sys_clk) disable iff (rst)
    (compare_clear_mode && eq && !tick && !counter_clear_bit
     && !counter_write) |=> cnt_ff == $past(cnt_ff))
    else $error("compare clear before tick");

  // A stopped write loads the counter
  a_stop_load: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_stop && counter_write && !counter_clear_bit)
    |=> cnt_ff == $past(counter_write_data))
    else $error("stopped write not loaded");

  // A write while running is ignored
  a_run_no_load: assert property (@(posedge sys_clk) disable iff (rst)
    (!timer_stop && counter_write && !counter_clear_bit && !tick)
    |=> cnt_ff == $past(cnt_ff))
    else $error("running write was loaded");

  // Overflow flag stays until its clear pulse
  a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (ovf_ff && !overflow_flag_clear)
    |=> ovf_ff)
    else $error("overflow flag lost");

  // Clear pulse drops the overflow flag
  a_ovf_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (overflow_flag_clear && !wrap)
    |=> !ovf_ff)
    else $error("overflow flag not cleared");

  // Overflow flag rises only on a wrap
  a_ovf_only_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (!ovf_ff && !wrap)
    |=> !ovf_ff)
    else $error("overflow flag without wrap");

  // Clear pulse drops the compare flag
  a_cflag_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (compare_flag_clear && !(compare_enable && tick && eq))
    |=> !cflag_ff)
    else $error("compare flag not cleared");

  // A match beats a coincident clear
  a_cflag_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (compare_flag_clear && compare_enable && tick && eq)
    |=> cflag_ff)
    else $error("clear beat compare match");

  // Match pulse only on a tick with equality
  a_match_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    !(compare_enable && tick && eq)
    |=> !match_ff)
    else $error("spurious compare match");

  // Disabled compare never matches
  a_cmp_disabled: assert property (@(posedge sys_clk) disable iff (rst)
    !compare_enable
    |=> !match_ff)
    else $error("compare matched while disabled");

  // Compare request follows its flag when enabled
  a_cmp_irq_set: assert property (@(posedge sys_clk) disable iff (rst)
    (cflag_ff && $past(compare_irq_enable_zero))
    |-> cirq_ff)
    else $error("compare interrupt missing");

  // No compare request without its flag
  a_cmp_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !cflag_ff
    |-> !cirq_ff)
    else $error("compare interrupt without flag");

  // No overflow request without its flag
  a_ovf_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !ovf_ff
    |-> !tirq_ff)
    else $error("overflow interrupt without flag");

  // Capture requests are gated by their enables
  a_cap_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_irq_enable == '0)
    |=> (capirq_ff == '0))
    else $error("capture interrupt while disabled");

  // An enabled capture flag raises its request
  a_cap_irq_set: assert property (@(posedge sys_clk) disable iff (rst)
    ((cap_flag & capture_irq_enable) != '0)
    |=> (capirq_ff != '0))
    else $error("capture interrupt missing");

  // Coincident clears give zero and still flag the overflow
  a_coincide: assert property (@(posedge sys_clk) disable iff (rst)
    (counter_clear_bit && wrap)
    |=> (cnt_ff == CNT_RESET && ovf_ff))
    else $error("coincident clear lost overflow");

  // No count tick while stopped
  a_stop_no_tick: assert property (@(posedge sys_clk) disable iff (rst)
    timer_stop
    |-> !tick)
    else $error("tick while stopped");
endmodule
`default_nettype wire

// ===== cap_pin_model.sv
// Model of the external sources on the capture input pins.
// Assumes the bench names the wanted levels; edges land off the clock.
`timescale 1ns/10ps
`default_nettype none
module cap_pin_model (
  input wire logic sys_clk,
  input wire logic [1:0] level,
  output logic [1:0] pin
);
  // Edges arrive between clock edges, like an unrelated source
  initial pin = 2'h0;
  always @(posedge sys_clk) begin
    pin <= #2.3 level;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the free-running timer, compare and capture.
// Assumes a 200 MHz sys_clk and the pin model on the capture inputs.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; \
  if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
  import frt_pkg::*;
  logic sys_clk = 0, rst = 1, timer_stop = 0, compare_clear_mode = 0;
  logic overflow_irq_enable = 0, counter_clear_bit = 0, counter_write = 0;
  logic overflow_flag_clear = 0, compare_enable = 0, compare_flag_clear = 0;
  logic compare_irq_enable_zero = 0, overflow_flag, compare_match;
  logic compare_flag_zero, timer_irq, compare_irq;
  logic [2:0] count_clock_sel = 3'h0;
  logic [15:0] counter_write_data = 16'h0000;
  logic [15:0] compare_value_zero = 16'hFFFF, timer_counter_data;
  logic [1:0] capture_pin, capture_irq_enable = 2'h1, capture_flag_clear = 0;
  logic [1:0] pin_level = 2'h0, capture_flags, capture_irq;
  logic [3:0] capture_edge_select = 4'h0;
  logic [31:0] capture_values;
  int n_errors = 0, check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  free_running_timer_capture_compare #(.N_CAP(2))
    free_running_timer_capture_compare_inst (.sys_clk, .rst, .timer_stop,
    .count_clock_sel, .compare_clear_mode, .overflow_irq_enable,
    .counter_clear_bit, .counter_write, .counter_write_data,
    .overflow_flag_clear, .compare_value_zero, .compare_enable,
    .compare_irq_enable_zero, .compare_flag_clear, .capture_pin,
    .capture_edge_select, .capture_irq_enable, .capture_flag_clear,
    .timer_counter_data, .overflow_flag, .compare_match, .compare_flag_zero,
    .capture_values, .capture_flags, .timer_irq, .compare_irq, .capture_irq);
  cap_pin_model cap_pin_model_inst (.sys_clk, .level(pin_level),
    .pin(capture_pin));
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [15:0] d);
    @(posedge sys_clk);
    counter_write <= 1'b1;
    counter_write_data <= d;
    @(posedge sys_clk);
    counter_write <= 1'b0;
  endtask
  task t_rate;
    logic [15:0] c;
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      count_clock_sel <= 3'(s);
      cyc(8);
      #1 c = timer_counter_data;
      cyc(16);
      #1 `CHK(timer_counter_data, 16'(c + (16 >> (s + 1))));
    end
    @(posedge sys_clk);
    count_clock_sel <= 3'h0;
  endtask
  task t_clear;
    cyc(3);
    @(posedge sys_clk);
    counter_clear_bit <= 1'b1;
    @(posedge sys_clk);
    counter_clear_bit <= 1'b0;
    #1 `CHK(timer_counter_data, CNT_RESET);
    wr(16'h1234);
    #1 `CHK(timer_counter_data == 16'h1234, 1'b0);
    @(posedge sys_clk);
    timer_stop <= 1'b1;
    wr(16'h00A0);
    wr(16'h0000);
    #1 `CHK(timer_counter_data, 16'h0000);
    @(posedge sys_clk);
    timer_stop <= 1'b0;
  endtask
  task t_ovf;
    int i;
    @(posedge sys_clk);
    timer_stop <= 1'b1;
    overflow_irq_enable <= 1'b1;
    wr(16'hFFFD);
    @(posedge sys_clk);
    timer_stop <= 1'b0;
    i = 0;
    while (overflow_flag !== 1'b1 && i < 40) begin
      @(posedge sys_clk);
      #1 i++;
    end
    `CHK(overflow_flag, 1'b1);
    `CHK(timer_counter_data, 16'h0000);
    cyc(2);
    #1 `CHK(timer_irq, 1'b1);
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b1;
    @(posedge sys_clk);
    overflow_flag_clear <= 1'b0;
    cyc(2);
    #1 `CHK(timer_irq, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1 `CHK(timer_counter_data, CNT_RESET);
  endtask
  task t_cmp;
    logic [15:0] mx;
    int nm;
    @(posedge sys_clk);
    timer_stop <= 1'b1;
    wr(16'h0000);
    @(posedge sys_clk);
    compare_value_zero <= 16'h0006;
    compare_enable <= 1'b1;
    compare_clear_mode <= 1'b1;
    compare_irq_enable_zero <= 1'b1;
    timer_stop <= 1'b0;
    mx = 16'h0000;
    nm = 0;
    repeat (60) begin
      @(posedge sys_clk);
      #1 if (timer_counter_data > mx) mx = timer_counter_data;
      if (compare_match === 1'b1) nm++;
    end
    `CHK(nm > 0, 1'b1);
    `CHK(mx, 16'h0006);
    `CHK(compare_flag_zero, 1'b1);
    `CHK(compare_irq, 1'b1);
    @(posedge sys_clk);
    timer_stop <= 1'b1;
    cyc(2);
    @(posedge sys_clk);
    compare_value_zero <= timer_counter_data;
    compare_flag_clear <= 1'b1;
    @(posedge sys_clk);
    compare_flag_clear <= 1'b0;
    cyc(20);
    #1 `CHK(compare_flag_zero, 1'b0);
  endtask
  task t_cap;
    logic [3:0] sel [5] = '{4'h9, 4'h9, 4'h9, 4'hC, 4'hC};
    logic [1:0] lvl [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [1:0] ex [5] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h2};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      capture_edge_select <= sel[i];
      wr(16'(16'h1230 + i));
      cyc(4);
      @(posedge sys_clk);
      capture_flag_clear <= 2'h3;
      @(posedge sys_clk);
      capture_flag_clear <= 2'h0;
      pin_level <= lvl[i];
      cyc(8);
      #1 `CHK(capture_flags, ex[i]);
      `CHK(capture_irq, ex[i] & 2'h1);
      if (ex[i][0])
        `CHK(capture_values[15:0], 16'(16'h1230 + i));
      if (ex[i][1])
        `CHK(capture_values[31:16], 16'(16'h1230 + i));
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc(6);
    #1 `CHK(timer_counter_data, CNT_RESET);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_rate;
    t_clear;
    t_ovf;
    t_cmp;
    t_cap;
    final_report;
  end
  initial begin
    #100us;
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
